//--- rfes_card_model.sv
// Behavioural contactless card that decodes carrier pauses from the envelope.
`timescale 1ns/10ps
module rfes_card_model #(
   parameter logic [7:0] THRESH = 8'h80
) (
   // Carrier clock and envelope seen through the antenna.
   input  wire logic       clk_i,
   input  wire logic [7:0] field_i,
   // Number of complete pauses decoded.
   output int              pauses_o
);
   logic low_r = 1'b0;
   int   cnt_r = 0;
   // One process owns the count; the port only shows it.
   assign pauses_o = cnt_r;
   // A pause counts only once the field has recovered, as a real demodulator sees it.
   always @(posedge clk_i) begin
      low_r <= (field_i < THRESH);
      if (low_r && !(field_i < THRESH)) begin
         cnt_r <= cnt_r + 1;
      end
   end
endmodule

//--- rfes_defines.svh
// Register offsets, field positions, codes and reset values of the edge shaper.
`ifndef RFES_DEFINES_SVH
`define RFES_DEFINES_SVH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define RFES_ADDR_RESIDUAL 8'h3C
`define RFES_ADDR_KIND     8'h59
`define RFES_ADDR_PARAMS   8'h5A
`define RFES_ADDR_COUNT    8'h5B
`define RFES_ADDR_STATUS   8'h5C
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define RFES_KIND_FALL 7:4
`define RFES_KIND_RISE 3:0
`define RFES_PAR_FALL  6:4
`define RFES_PAR_RISE  2:0
`define RFES_CNT_DBL   7
`define RFES_CNT_N     4:0
`define RFES_LUT_PT    7:5
`define RFES_LUT_IDX   1:0
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RFES_RST_RESIDUAL 8'h00
`define RFES_RST_KIND     8'h11
`define RFES_RST_PARAMS   7'h00
`define RFES_RST_COUNT    6'h08
// ------------------------------------------------------------
// Style codes, levels, scaling shifts and phase codes
// ------------------------------------------------------------
`define RFES_STYLE_LIN1     4'h1
`define RFES_STYLE_LIN2     4'h2
`define RFES_STYLE_LIN3     4'h3
`define RFES_STYLE_LUT      4'h4
`define RFES_STYLE_LUT_CORR 4'h5
`define RFES_STYLE_LUT_ADPT 4'h6
`define RFES_FULL   8'hFF
`define RFES_ZERO   8'h00
`define RFES_HALF   8'h80
`define RFES_THIRD1 8'h40
`define RFES_THIRD2 8'hC0
`define RFES_SH_UNIT 8
`define RFES_SH_WIDE 7
`define RFES_SH_NARR 6
`define RFES_SH_CORR 2
`define RFES_PH_IDLE  2'h0
`define RFES_PH_FALL  2'h1
`define RFES_PH_PAUSE 2'h2
`define RFES_PH_RISE  2'h3
`endif

//--- rfes_edge_shaper.sv
// Amplitude of one edge at a given transition state, for every style code.
`timescale 1ns/10ps
`include "rfes_defines.svh"
module rfes_edge_shaper (
   // Edge configuration.
   input  rfes_pkg::rfes_style_t style_i,
   input  wire logic [2:0]       param_i,
   input  wire logic             fall_i,
   input  rfes_pkg::rfes_level_t res_i,
   input  rfes_pkg::rfes_level_t sup_i,
   // Position within the edge.
   input  wire logic [4:0]       k_i,
   input  wire logic [4:0]       n_i,
   // Shaped amplitude.
   output rfes_pkg::rfes_level_t amp_o
);
   import rfes_pkg::*;

   localparam logic [7:0] LUT [4][8] = '{
      '{8'h00, 8'h24, 8'h49, 8'h6D, 8'h92, 8'hB6, 8'hDB, 8'hFF},
      '{8'h00, 8'h04, 8'h10, 8'h24, 8'h40, 8'h64, 8'h90, 8'hC4},
      '{8'h00, 8'h3C, 8'h70, 8'h9C, 8'hC0, 8'hDC, 8'hF0, 8'hFC},
      '{8'h00, 8'h0C, 8'h30, 8'h68, 8'h98, 8'hD0, 8'hF4, 8'hFC}};

   logic [12:0] num;
   logic [7:0]  frac;
   logic [7:0]  g;
   logic [7:0]  knee;
   logic [7:0]  lo;
   logic [7:0]  hi;
   logic [7:0]  pt;
   logic [7:0]  adapt;
   logic [8:0]  sum;
   logic [7:0]  span;
   logic [7:0]  delta;
   logic        valid;

   // Progress fraction k/n in 1/255 steps, then the style maps it to a shape.
   always_comb begin
      num   = 13'(k_i) * {5'h00, `RFES_FULL};
      frac  = (n_i == 5'h00) ? `RFES_FULL : 8'(num / 13'(n_i));
      knee  = {param_i, 5'h10};
      lo    = {1'b0, param_i, 4'h0};
      hi    = `RFES_FULL - lo;
      pt    = LUT[param_i[`RFES_LUT_IDX]][frac[`RFES_LUT_PT]]; // see R9
      adapt = 8'((16'(pt) * 16'(sup_i)) >> `RFES_SH_UNIT);
      sum   = 9'(adapt) + 9'((`RFES_FULL - sup_i) >> `RFES_SH_CORR);
      valid = 1'b1;
      g     = frac;
      case (style_i)
         `RFES_STYLE_LIN1: begin // see R3
            g = frac;
         end
         `RFES_STYLE_LIN2: begin // see R3, R7, R8
            if (frac < `RFES_HALF) begin
               g = 8'((16'(frac) * 16'(knee)) >> `RFES_SH_WIDE);
            end else begin
               g = knee + 8'((16'(frac - `RFES_HALF) * 16'(`RFES_FULL - knee)) >> `RFES_SH_WIDE);
            end
         end
         `RFES_STYLE_LIN3: begin // see R3, R7, R8
            if (frac < `RFES_THIRD1) begin
               g = 8'((16'(frac) * 16'(lo)) >> `RFES_SH_NARR);
            end else if (frac < `RFES_THIRD2) begin
               g = lo + 8'((16'(frac - `RFES_THIRD1) * 16'(hi - lo)) >> `RFES_SH_WIDE);
            end else begin
               g = hi + 8'((16'(frac - `RFES_THIRD2) * 16'(`RFES_FULL - hi)) >> `RFES_SH_NARR);
            end
         end
         `RFES_STYLE_LUT: begin // see R4
            g = pt;
         end
         `RFES_STYLE_LUT_CORR: begin // see R5
            g = sum[8] ? `RFES_FULL : sum[7:0];
         end
         `RFES_STYLE_LUT_ADPT: begin // see R6
            g = adapt;
         end
         default: begin // see R14
            valid = 1'b0;
         end
      endcase
   end

   // Map the shape onto the span between full carrier and the residual level.
   always_comb begin
      span  = `RFES_FULL - res_i;
      delta = 8'((16'(span) * 16'(g)) >> `RFES_SH_UNIT);
      if (k_i == n_i || !valid) begin // see R14
         amp_o = fall_i ? res_i : `RFES_FULL;
      end else begin
         amp_o = fall_i ? (`RFES_FULL - delta) : (res_i + delta);
      end
   end
endmodule

//--- rfes_pkg.sv
// Types shared by the edge shaper modules.
package rfes_pkg;
   typedef logic [3:0] rfes_style_t;
   typedef logic [7:0] rfes_level_t;
   typedef enum logic [1:0] {ST_IDLE, ST_FALL, ST_PAUSE, ST_RISE} rfes_state_e;
endpackage

//--- rfes_shaper_top.sv
// Carrier envelope shaper for reader-mode modulation pauses, with its registers.
// Operation
// R1: The falling-edge style code is the upper nibble of the edge-kind register.
// R2: The rising-edge style code is the lower nibble of that register, set independently.
// R3: Codes one to three shape the edge with one, two or three linear ramps; zero and seven to fifteen are reserved.
// R4: Code four uses a stored table with no supply adaptation.
// R5: Code five uses a table adapted to the amplifier supply plus a correction step.
// R6: Code six uses a table adapted to the amplifier supply without correction.
// R7: For computed falling edges the three-bit falling parameter sets the time constant.
// R8: For computed rising edges the three-bit rising parameter sets the time constant.
// R9: For table styles each edge parameter picks table zero to three.
// R10: Each transition state lasts one carrier cycle, or two when the doubling bit is set.
// R11: Both edges step through the number of states given by the shared five-bit count.
// R12: During the pause the carrier level is the eight-bit residual value, zero none, all ones full.
// R13: Intermediate residual values scale the carrier linearly in steps of 1/255.
// R14: Reserved bits are ignored and reserved style codes give a plain step edge.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
`include "rfes_defines.svh"
module rfes_shaper_top (
   // Clock and reset.
   input  wire logic        CLK_I,
   input  wire logic        SRST_I,
   // Register port.
   input  wire logic [7:0]  ADDR_I,
   input  wire logic [7:0]  WDATA_I,
   input  wire logic        WR_I,
   input  wire logic        RD_I,
   output logic [7:0]       RDATA_O,
   // Modulation request and amplifier supply measurement.
   input  wire logic        MOD_PAUSE_I,
   input  rfes_pkg::rfes_level_t PA_SUPPLY_I,
   // Carrier envelope.
   output rfes_pkg::rfes_level_t AMPL_O,
   output logic             EDGE_BUSY_O
);
   import rfes_pkg::*;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0]  residual_r;
   logic [7:0]  residual_nxt;
   logic [7:0]  kind_r;
   logic [7:0]  kind_nxt;
   logic [6:0]  params_r;
   logic [6:0]  params_nxt;
   logic [5:0]  count_r;
   logic [5:0]  count_nxt;
   logic [7:0]  rdata_r;
   logic [7:0]  rdata_nxt;
   logic [1:0]  phase;

   // Edge engine state.
   rfes_state_e state_r;
   rfes_state_e state_nxt;
   logic [4:0]  k_r;
   logic [4:0]  k_nxt;
   logic [7:0]  amp_r;
   logic [7:0]  amp_nxt;
   logic        busy_r;
   logic        busy_nxt;
   logic [7:0]  sup_meta_r;
   logic [7:0]  sup_r;
   logic [4:0]  n;
   logic [4:0]  k_next;
   logic        run;
   logic        step;
   logic        last;
   logic [7:0]  fall_amp;
   logic [7:0]  rise_amp;

   // Writes store only the defined bits, so reserved bits always read back zero.
   always_comb begin
      residual_nxt = residual_r;
      kind_nxt     = kind_r;
      params_nxt   = params_r;
      count_nxt    = count_r;
      if (WR_I) begin
         if (ADDR_I == `RFES_ADDR_RESIDUAL) begin
            residual_nxt = WDATA_I;
         end else if (ADDR_I == `RFES_ADDR_KIND) begin
            kind_nxt = WDATA_I;
         end else if (ADDR_I == `RFES_ADDR_PARAMS) begin
            params_nxt = {WDATA_I[`RFES_PAR_FALL], 1'b0, WDATA_I[`RFES_PAR_RISE]}; // see R14
         end else if (ADDR_I == `RFES_ADDR_COUNT) begin
            count_nxt = {WDATA_I[`RFES_CNT_DBL], WDATA_I[`RFES_CNT_N]}; // see R14
         end
      end
   end

   // Read data appear in the cycle after the strobe; unmapped offsets read zero.
   always_comb begin
      rdata_nxt = `RFES_ZERO;
      if (RD_I) begin
         if (ADDR_I == `RFES_ADDR_RESIDUAL) begin
            rdata_nxt = residual_r;
         end else if (ADDR_I == `RFES_ADDR_KIND) begin
            rdata_nxt = kind_r;
         end else if (ADDR_I == `RFES_ADDR_PARAMS) begin
            rdata_nxt = {1'b0, params_r};
         end else if (ADDR_I == `RFES_ADDR_COUNT) begin
            rdata_nxt = {count_r[5], 2'h0, count_r[4:0]};
         end else if (ADDR_I == `RFES_ADDR_STATUS) begin
            rdata_nxt = {phase, 1'b0, k_r};
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         residual_r <= `RFES_RST_RESIDUAL;
         kind_r     <= `RFES_RST_KIND;
         params_r   <= `RFES_RST_PARAMS;
         count_r    <= `RFES_RST_COUNT;
         rdata_r    <= `RFES_ZERO;
      end else begin
         residual_r <= residual_nxt;
         kind_r     <= kind_nxt;
         params_r   <= params_nxt;
         count_r    <= count_nxt;
         rdata_r    <= rdata_nxt;
      end
   end

   assign RDATA_O = rdata_r;

   // ------------------------------------------------------------
   // Supply synchroniser
   // ------------------------------------------------------------
   // The supply word comes from a slow converter; it must hold still for
   // several cycles per update, since each bit is synchronised on its own.
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         sup_meta_r <= `RFES_FULL;
         sup_r      <= `RFES_FULL;
      end else begin
         sup_meta_r <= PA_SUPPLY_I;
         sup_r      <= sup_meta_r;
      end
   end

   // ------------------------------------------------------------
   // Edge engine
   // ------------------------------------------------------------
   assign n      = count_r[4:0];
   assign k_next = k_r + 5'h01;
   assign run    = (state_r == ST_FALL) || (state_r == ST_RISE);
   assign last   = (k_next == n);

   rfes_step_timer u_timer (
      .CLK_I  (CLK_I),
      .SRST_I (SRST_I),
      .run_i  (run),
      .dbl_i  (count_r[5]),
      .step_o (step)
   );

   // Falling edge: upper style nibble and upper parameter field.
   rfes_edge_shaper u_fall (
      .style_i (kind_r[`RFES_KIND_FALL]),
      .param_i (params_r[6:4]),
      .fall_i  (1'b1),
      .res_i   (residual_r),
      .sup_i   (sup_r),
      .k_i     (k_next),
      .n_i     (n),
      .amp_o   (fall_amp)
   ); // see R1, R7

   // Rising edge: lower style nibble and lower parameter field.
   rfes_edge_shaper u_rise (
      .style_i (kind_r[`RFES_KIND_RISE]),
      .param_i (params_r[2:0]),
      .fall_i  (1'b0),
      .res_i   (residual_r),
      .sup_i   (sup_r),
      .k_i     (k_next),
      .n_i     (n),
      .amp_o   (rise_amp)
   ); // see R2, R8

   // A pause request that ends during the falling edge still finishes that
   // edge, so the card always sees a complete pulse shape.
   always_comb begin
      state_nxt = state_r;
      k_nxt     = k_r;
      amp_nxt   = amp_r;
      case (state_r)
         ST_IDLE: begin
            amp_nxt = `RFES_FULL;
            k_nxt   = 5'h00;
            if (MOD_PAUSE_I) begin
               if (n == 5'h00) begin
                  state_nxt = ST_PAUSE;
                  amp_nxt   = residual_r;
               end else begin
                  state_nxt = ST_FALL;
               end
            end
         end
         ST_FALL: begin
            if (step) begin // see R10, R11
               amp_nxt = fall_amp;
               k_nxt   = k_next;
               if (last) begin
                  state_nxt = ST_PAUSE;
                  k_nxt     = 5'h00;
               end
            end
         end
         ST_PAUSE: begin
            amp_nxt = residual_r; // see R12, R13
            if (!MOD_PAUSE_I) begin
               if (n == 5'h00) begin
                  state_nxt = ST_IDLE;
               end else begin
                  state_nxt = ST_RISE;
               end
            end
         end
         ST_RISE: begin
            if (step) begin // see R10, R11
               amp_nxt = rise_amp;
               k_nxt   = k_next;
               if (last) begin
                  state_nxt = ST_IDLE;
                  k_nxt     = 5'h00;
               end
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      busy_nxt = (state_nxt == ST_FALL) || (state_nxt == ST_RISE);
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         state_r <= ST_IDLE;
         k_r     <= 5'h00;
         amp_r   <= `RFES_FULL;
         busy_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         k_r     <= k_nxt;
         amp_r   <= amp_nxt;
         busy_r  <= busy_nxt;
      end
   end

   // Phase code for the status register.
   always_comb begin
      case (state_r)
         ST_FALL:  phase = `RFES_PH_FALL;
         ST_PAUSE: phase = `RFES_PH_PAUSE;
         ST_RISE:  phase = `RFES_PH_RISE;
         default:  phase = `RFES_PH_IDLE;
      endcase
   end

   assign AMPL_O      = amp_r;
   assign EDGE_BUSY_O = busy_r;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_fall_start: assert property (@(posedge CLK_I) disable iff (SRST_I) // see R11
      (state_r == ST_IDLE && MOD_PAUSE_I && n != 5'h00) |=> (state_r == ST_FALL && k_r == 5'h00))
      else $error("falling edge did not start on pause request");

   a_fall_end: assert property (@(posedge CLK_I) disable iff (SRST_I) // see R11
      (state_r == ST_FALL && step && k_r + 5'h01 == n) |=> (state_r == ST_PAUSE && AMPL_O == $past(residual_r)))
      else $error("falling edge did not end at the residual level after n states");

   a_rise_end: assert property (@(posedge CLK_I) disable iff (SRST_I) // see R11
      (state_r == ST_RISE && step && k_r + 5'h01 == n) |=> (state_r == ST_IDLE && AMPL_O == `RFES_FULL))
      else $error("rising edge did not end at full carrier after n states");

   a_pause_level: assert property (@(posedge CLK_I) disable iff (SRST_I) // see R12
      (state_r == ST_PAUSE) |=> (AMPL_O == $past(residual_r)))
      else $error("pause level differs from the residual setting");

   a_idle_full: assert property (@(posedge CLK_I) disable iff (SRST_I) // see R12
      (state_r == ST_IDLE && $past(state_r) == ST_IDLE) |-> (AMPL_O == `RFES_FULL))
      else $error("carrier not full while idle");

   a_step_fallback: assert property (@(posedge CLK_I) disable iff (SRST_I) // see R14
      (state_r == ST_FALL && step && (kind_r[`RFES_KIND_FALL] == 4'h0 || kind_r[`RFES_KIND_FALL] > 4'h6))
      |=> (AMPL_O == $past(residual_r)))
      else $error("reserved falling style did not give a step edge");

   a_read_reserved: assert property (@(posedge CLK_I) disable iff (SRST_I) // see R14
      (RD_I && ADDR_I == `RFES_ADDR_PARAMS) |=> (RDATA_O[7] == 1'b0 && RDATA_O[3] == 1'b0))
      else $error("reserved parameter bits read nonzero");

   a_fall_count: assert property (@(posedge CLK_I) disable iff (SRST_I) // see R10
      (state_r == ST_FALL && step && !count_r[5] && k_r + 5'h01 != n) |=> (k_r == $past(k_r) + 5'h01))
      else $error("state index did not advance by one");
endmodule

//--- rfes_step_timer.sv
// Transition-state timer: one step pulse per carrier cycle, or per two.
`timescale 1ns/10ps
`include "rfes_defines.svh"
module rfes_step_timer (
   // Clock and reset.
   input  wire logic CLK_I,
   input  wire logic SRST_I,
   // Control and step strobe.
   input  wire logic run_i,
   input  wire logic dbl_i,
   output logic      step_o
);
   import rfes_pkg::*;

   logic half_r;
   logic half_nxt;

   // Half toggles only while a doubled edge runs, so every state spans two cycles.
   always_comb begin
      half_nxt = (run_i && dbl_i) ? ~half_r : 1'b0;
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         half_r <= 1'b0;
      end else begin
         half_r <= half_nxt;
      end
   end

   // A state ends after one cycle, or after its second cycle when doubled.
   assign step_o = run_i && (!dbl_i || half_r); // see R10

   a_single_hold: assert property (@(posedge CLK_I) disable iff (SRST_I) // see R10
      (run_i && !dbl_i) |-> step_o)
      else $error("single-length state did not step every cycle");

   a_double_hold: assert property (@(posedge CLK_I) disable iff (SRST_I) // see R10
      (run_i && dbl_i && step_o) |-> ($past(run_i) && !$past(step_o)))
      else $error("doubled state stepped after one cycle");
endmodule

//--- tb_rfes_shaper_top.sv
// Self-checking bench for the carrier envelope shaper.
`timescale 1ns/10ps
`include "rfes_defines.svh"
module tb_rfes_shaper_top;
   import rfes_pkg::*;
   // ------------------------------------------------------------
   // Signals, clock and instances
   // ------------------------------------------------------------
   logic        clk_i = 1'b0;
   logic        srst = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [7:0]  rdata;
   logic        mod_pause = 1'b0;
   rfes_level_t pa_supply = 8'h80;
   rfes_level_t ampl;
   logic        edge_busy;
   int          pauses;
   int          n_errors = 0;
   int          compares = 0;
   // Carrier clock at 50 MHz.
   always #10 clk_i = ~clk_i;
   rfes_shaper_top i_dut (
      .CLK_I(clk_i), .SRST_I(srst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
      .RDATA_O(rdata), .MOD_PAUSE_I(mod_pause), .PA_SUPPLY_I(pa_supply), .AMPL_O(ampl),
      .EDGE_BUSY_O(edge_busy)
   );
   rfes_card_model i_card (
      .clk_i(clk_i), .field_i(ampl), .pauses_o(pauses)
   );
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   // Compare one byte and report a mismatch at once.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One-cycle register write.
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask
   // Read, check the data cycle, then check that the bus returns to zero.
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      @(negedge clk_i);
      chk(rdata, exp);
      @(negedge clk_i);
      chk(rdata, 8'h00);
   endtask
   // Set the pause request level and run one edge; count busy cycles and catch the first state value.
   task automatic do_edge(input logic lvl, input int dbl, output int cnt, output rfes_level_t first);
      int i;
      i = 0;
      cnt = 0;
      first = 8'h00;
      @(posedge clk_i);
      mod_pause <= lvl;
      do begin
         @(negedge clk_i);
         i++;
      end while (edge_busy !== 1'b1 && i < 10);
      while (edge_busy === 1'b1 && cnt < 80) begin
         @(negedge clk_i);
         cnt++;
         if (cnt == 1 + dbl) first = ampl;
      end
   endtask
   // Amplitude of a ramp at ramp fraction g between the residual and full carrier.
   function automatic rfes_level_t shp(input rfes_level_t res, input int g, input logic fall);
      int d;
      d = ((255 - int'(res)) * g) >> 8;
      return fall ? 8'(255 - d) : 8'(int'(res) + d);
   endfunction
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      rd_chk(`RFES_ADDR_RESIDUAL, 8'h00);
      rd_chk(`RFES_ADDR_KIND, 8'h11);
      rd_chk(`RFES_ADDR_PARAMS, 8'h00);
      rd_chk(`RFES_ADDR_COUNT, 8'h08);
      wr_reg(`RFES_ADDR_PARAMS, 8'hFF);
      wr_reg(`RFES_ADDR_COUNT, 8'hFF);
      wr_reg(`RFES_ADDR_KIND, 8'hA5);
      wr_reg(8'h10, 8'h55);
      rd_chk(`RFES_ADDR_PARAMS, 8'h77);
      rd_chk(`RFES_ADDR_COUNT, 8'h9F);
      rd_chk(`RFES_ADDR_KIND, 8'hA5);
      rd_chk(8'h10, 8'h00);
      wr_reg(`RFES_ADDR_PARAMS, 8'h00);
      $display("test regs done");
   endtask
   // Edge length for count one, count two doubled, and the maximum count with and without doubling.
   task automatic t_timing();
      int tn[4] = '{1, 2, 31, 31};
      int td[4] = '{0, 1, 0, 1};
      int cnt;
      int p0;
      rfes_level_t first;
      wr_reg(`RFES_ADDR_KIND, 8'h11);
      wr_reg(`RFES_ADDR_RESIDUAL, 8'h40);
      for (int j = 0; j < 4; j++) begin
         wr_reg(`RFES_ADDR_COUNT, {td[j][0], 2'b00, tn[j][4:0]});
         p0 = pauses;
         do_edge(1'b1, td[j], cnt, first);
         chk(8'(cnt), 8'(tn[j] * (1 + td[j])));
         chk(ampl, 8'h40);
         if (tn[j] > 1) chk(first, shp(8'h40, 255 / tn[j], 1'b1));
         do_edge(1'b0, td[j], cnt, first);
         chk(8'(cnt), 8'(tn[j] * (1 + td[j])));
         chk(ampl, 8'hFF);
         if (tn[j] > 1) chk(first, shp(8'h40, 255 / tn[j], 1'b0));
         @(negedge clk_i);
         chk(8'(pauses - p0), 8'h01);
      end
      // A zero count gives plain steps with no busy phase.
      wr_reg(`RFES_ADDR_COUNT, 8'h00);
      @(posedge clk_i);
      mod_pause <= 1'b1;
      repeat (3) @(negedge clk_i);
      chk(ampl, 8'h40);
      chk({7'h00, edge_busy}, 8'h00);
      @(posedge clk_i);
      mod_pause <= 1'b0;
      repeat (3) @(negedge clk_i);
      chk(ampl, 8'hFF);
      $display("test timing done");
   endtask
   // Every code on each edge, the two nibbles always set to different codes.
   task automatic t_styles();
      int cnt;
      logic [3:0] rc;
      rfes_level_t first;
      wr_reg(`RFES_ADDR_COUNT, 8'h04);
      // Falling parameter seven, so the two- and three-ramp shapes leave their defaults.
      wr_reg(`RFES_ADDR_PARAMS, 8'h70);
      for (int c = 0; c < 16; c++) begin
         rc = 4'(15 - c);
         wr_reg(`RFES_ADDR_KIND, {4'(c), rc});
         do_edge(1'b1, 0, cnt, first);
         chk(8'(cnt), 8'h04);
         chk(ampl, 8'h40);
         if (c == 0 || c > 6) chk(first, 8'h40);
         if (c == 1) chk(first, shp(8'h40, 63, 1'b1));
         if (c == 2) chk(first, shp(8'h40, 63 * 240 / 128, 1'b1));
         if (c == 3) chk(first, shp(8'h40, 63 * 112 / 64, 1'b1));
         do_edge(1'b0, 0, cnt, first);
         chk(8'(cnt), 8'h04);
         chk(ampl, 8'hFF);
         if (rc == 0 || rc > 6) chk(first, 8'hFF);
         if (rc == 1) chk(first, shp(8'h40, 63, 1'b0));
      end
      $display("test styles done");
   endtask
   // Run a table style at a given supply and return the first falling state value.
   task automatic sup_edge(input logic [7:0] kind, input rfes_level_t sup, output rfes_level_t first);
      int cnt;
      rfes_level_t tmp;
      wr_reg(`RFES_ADDR_KIND, kind);
      pa_supply <= sup;
      repeat (4) @(posedge clk_i);
      do_edge(1'b1, 0, cnt, first);
      chk(ampl, 8'h00);
      do_edge(1'b0, 0, cnt, tmp);
      chk(ampl, 8'hFF);
   endtask
   // With no supply headroom the adapted table is flat and only the correction remains.
   task automatic t_supply();
      rfes_level_t a;
      rfes_level_t b;
      wr_reg(`RFES_ADDR_RESIDUAL, 8'h00);
      sup_edge(8'h66, 8'h00, a);
      chk(a, 8'hFF);
      sup_edge(8'h55, 8'h00, a);
      chk(a, shp(8'h00, 63, 1'b1));
      sup_edge(8'h44, 8'h00, a);
      sup_edge(8'h44, 8'hFF, b);
      chk(a, b);
      // Table three above, table zero now: the first state must move.
      wr_reg(`RFES_ADDR_PARAMS, 8'h40);
      sup_edge(8'h44, 8'hFF, b);
      compares++;
      if (a === b) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=not %h", $time, b, a);
      end
      pa_supply <= 8'h80;
      $display("test supply done");
   endtask
   // Pause level follows the residual byte, also when it changes within a pause.
   task automatic t_residual();
      int cnt;
      rfes_level_t first;
      logic [7:0] lv[3] = '{8'h00, 8'h5A, 8'hFF};
      wr_reg(`RFES_ADDR_KIND, 8'h11);
      wr_reg(`RFES_ADDR_COUNT, 8'h01);
      for (int j = 0; j < 3; j++) begin
         wr_reg(`RFES_ADDR_RESIDUAL, lv[j]);
         do_edge(1'b1, 0, cnt, first);
         chk(ampl, lv[j]);
         wr_reg(`RFES_ADDR_RESIDUAL, ~lv[j]);
         // The pause level follows the register one cycle after the write lands.
         repeat (2) @(negedge clk_i);
         chk(ampl, ~lv[j]);
         rd_chk(`RFES_ADDR_STATUS, 8'h80);
         do_edge(1'b0, 0, cnt, first);
         chk(ampl, 8'hFF);
      end
      $display("test residual done");
   endtask
   // ------------------------------------------------------------
   // Verdict, watchdog and main sequence
   // ------------------------------------------------------------
   task automatic conclude();
      $display("compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // The whole run needs under a thousand cycles; 5000 cycles means a hang.
   initial begin
      #100_000;
      n_errors++;
      conclude();
   end
   initial begin
      repeat (5) @(posedge clk_i);
      srst <= 1'b0;
      t_regs();
      t_timing();
      t_styles();
      t_supply();
      t_residual();
      conclude();
   end
endmodule
